// >>> shared/atir_pkg.sv
// atir_pkg: constants of the taskfile register bank and identify table
// Notes on behaviour
// - sixteen-bit data port at offset 0x00 moves words in both directions.
// - offset 0x01 reads the error byte and writes the feature byte.
// - offset 0x07 reads the status byte; writes there deliver the opcode.
// - offsets 0x02 to 0x06 are plain read/write byte registers.
// - commands use 28-bit block addresses spread over low, mid, high, unit.
// - identify word 255 holds A5h low and a checksum byte high.
// - identify word 105 reads 0008h, data set management block limit.
// - identify word 169 reads 0001h, data set management supported.
// - identify word 234 reads 0001h, least firmware download blocks.
// - identify word 235 reads 0080h, most firmware download blocks.
// - identify word 217 reads 0001h, non-rotating media.
// - identify word 106 reads 4000h, physical versus logical sector size.
// - identify word 209 reads 4000h, logical block alignment.
// - identify word 222 reads 107Fh and word 223 reads zero.
// - identify word 168 gives form factor 3h, 4h or 5h.
// - identify words 210 to 213 read zero.
// - maximum user address words follow the capacity; 28-bit field reads 00FFFFFFh at 256G.
package atir_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] ATIR_IDX_DATA = 4'h0;
  localparam logic [3:0] ATIR_IDX_FAULT = 4'h1;
  localparam logic [3:0] ATIR_IDX_COUNT = 4'h2;
  localparam logic [3:0] ATIR_IDX_LBA_LOW = 4'h3;
  localparam logic [3:0] ATIR_IDX_LBA_MID = 4'h4;
  localparam logic [3:0] ATIR_IDX_LBA_HIGH = 4'h5;
  localparam logic [3:0] ATIR_IDX_UNIT = 4'h6;
  localparam logic [3:0] ATIR_IDX_OPCODE = 4'h7;
  localparam logic [3:0] ATIR_IDX_IRQ_ST = 4'h8;
  localparam logic [3:0] ATIR_IDX_IRQ_MASK = 4'h9;
  localparam logic [3:0] ATIR_IDX_ID_PTR = 4'ha;
  // status byte fields
  localparam int ATIR_ST_BSY = 7;
  localparam int ATIR_ST_DRDY = 6;
  localparam int ATIR_ST_DRQ = 3;
  localparam int ATIR_ST_ERR = 0;
  localparam logic [7:0] ATIR_ERR_ABRT = 8'h04;
  localparam logic [7:0] ATIR_CMD_IDENTIFY = 8'hec;
  // interrupt status fields
  localparam int ATIR_EV_DRQ = 0;
  localparam int ATIR_EV_DONE = 1;
  // reset values
  localparam logic [7:0] ATIR_RST_BYTE = 8'h00;
  localparam logic [1:0] ATIR_RST_MASK = 2'h0;
  // identify word indices and fixed values
  localparam logic [7:0] ATIR_W_LBA28 = 8'h3c;
  localparam logic [7:0] ATIR_W_LBA48 = 8'h64;
  localparam logic [7:0] ATIR_W_DSM_MAX = 8'h69;
  localparam logic [15:0] ATIR_V_DSM_MAX = 16'h0008;
  localparam logic [7:0] ATIR_W_SECT_SIZE = 8'h6a;
  localparam logic [15:0] ATIR_V_SECT_SIZE = 16'h4000;
  localparam logic [7:0] ATIR_W_SETTINGS = 8'h77;
  localparam logic [7:0] ATIR_W_FEAT_EN = 8'h78;
  localparam logic [15:0] ATIR_V_SETTINGS = 16'h4014;
  localparam logic [7:0] ATIR_W_SECURITY = 8'h80;
  localparam logic [15:0] ATIR_V_SECURITY = 16'h0021;
  localparam logic [7:0] ATIR_W_VENDOR = 8'h8d;
  localparam logic [15:0] ATIR_V_VENDOR = 16'h0001;
  localparam logic [7:0] ATIR_W_FORM = 8'ha8;
  localparam logic [7:0] ATIR_W_DSM_SUP = 8'ha9;
  localparam logic [15:0] ATIR_V_DSM_SUP = 16'h0001;
  localparam logic [7:0] ATIR_W_ALIGN = 8'hd1;
  localparam logic [15:0] ATIR_V_ALIGN = 16'h4000;
  localparam logic [7:0] ATIR_W_WRV_FIRST = 8'hd2;
  localparam logic [7:0] ATIR_W_WRV_LAST = 8'hd5;
  localparam logic [7:0] ATIR_W_NONROT = 8'hd9;
  localparam logic [15:0] ATIR_V_NONROT = 16'h0001;
  localparam logic [7:0] ATIR_W_TMAJOR = 8'hde;
  localparam logic [15:0] ATIR_V_TMAJOR = 16'h107f;
  localparam logic [7:0] ATIR_W_TMINOR = 8'hdf;
  localparam logic [7:0] ATIR_W_DL_MIN = 8'hea;
  localparam logic [15:0] ATIR_V_DL_MIN = 16'h0001;
  localparam logic [7:0] ATIR_W_DL_MAX = 8'heb;
  localparam logic [15:0] ATIR_V_DL_MAX = 16'h0080;
  localparam logic [7:0] ATIR_W_INTEGRITY = 8'hff;
  localparam logic [7:0] ATIR_SIGNATURE = 8'ha5;
  // capacity dependent maximum user addresses
  localparam logic [31:0] ATIR_LBA28_64G = 32'h07740ab0;
  localparam logic [31:0] ATIR_LBA28_128G = 32'h0ee7c2b0;
  localparam logic [31:0] ATIR_LBA28_256G = 32'h00ffffff;
  localparam logic [31:0] ATIR_LBA48_256G = 32'h1dcf32b0;
endpackage

// >>> rtl/atir_id_rom.sv
// atir_id_rom: identify data table with registered read word
module atir_id_rom
  import atir_pkg::*;
#(
  parameter int CAP_SEL = 0,
  parameter logic [3:0] FORM = 4'h3
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // read port
  input wire logic [7:0] addr_in,
  output logic [15:0] data_out
);
  localparam logic [31:0] LBA28 = (CAP_SEL == 0) ? ATIR_LBA28_64G :
    (CAP_SEL == 1) ? ATIR_LBA28_128G : ATIR_LBA28_256G;
  localparam logic [31:0] LBA48 = (CAP_SEL == 0) ? ATIR_LBA28_64G :
    (CAP_SEL == 1) ? ATIR_LBA28_128G : ATIR_LBA48_256G;

  if (CAP_SEL > 2 || FORM < 4'h3 || FORM > 4'h5) begin : bad_param
    $error("atir_id_rom: capacity or form factor out of range");
  end

  function automatic logic [15:0] base_word(input logic [7:0] a);
    logic [15:0] w;
    w = 16'h0000;
    if (a == ATIR_W_LBA28) w = LBA28[15:0];
    else if (a == ATIR_W_LBA28 + 8'h01) w = LBA28[31:16];
    else if (a == ATIR_W_LBA48) w = LBA48[15:0];
    else if (a == ATIR_W_LBA48 + 8'h01) w = LBA48[31:16];
    else if (a == ATIR_W_DSM_MAX) w = ATIR_V_DSM_MAX;
    else if (a == ATIR_W_SECT_SIZE) w = ATIR_V_SECT_SIZE;
    else if (a == ATIR_W_SETTINGS) w = ATIR_V_SETTINGS;
    else if (a == ATIR_W_FEAT_EN) w = ATIR_V_SETTINGS;
    else if (a == ATIR_W_SECURITY) w = ATIR_V_SECURITY;
    else if (a == ATIR_W_VENDOR) w = ATIR_V_VENDOR;
    else if (a == ATIR_W_FORM) w = {12'h000, FORM};
    else if (a == ATIR_W_DSM_SUP) w = ATIR_V_DSM_SUP;
    else if (a == ATIR_W_ALIGN) w = ATIR_V_ALIGN;
    else if (a == ATIR_W_NONROT) w = ATIR_V_NONROT;
    else if (a == ATIR_W_TMAJOR) w = ATIR_V_TMAJOR;
    else if (a == ATIR_W_DL_MIN) w = ATIR_V_DL_MIN;
    else if (a == ATIR_W_DL_MAX) w = ATIR_V_DL_MAX;
    else if (a == ATIR_W_INTEGRITY) w = {8'h00, ATIR_SIGNATURE};
    return w;
  endfunction

  // negated byte sum of the whole table with the checksum byte at zero
  function automatic logic [7:0] calc_check();
    logic [7:0] sum;
    logic [15:0] w;
    sum = 8'h00;
    for (int i = 0; i < 256; i++) begin
      w = base_word(8'(i));
      sum = sum + w[7:0] + w[15:8];
    end
    return 8'(8'h00 - sum);
  endfunction

  localparam logic [7:0] CHECK = calc_check();

  typedef struct packed {
    logic [15:0] data;
  } atir_rom_state_type;

  atir_rom_state_type s;
  atir_rom_state_type next_s;

  always_comb begin
    next_s = s;
    next_s.data = base_word(addr_in);
    if (addr_in == ATIR_W_INTEGRITY) begin
      next_s.data[15:8] = CHECK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign data_out = s.data;

  integrity_word_a: assert property (@(posedge clk_in) disable iff (rst_in)
    addr_in == ATIR_W_INTEGRITY |=> data_out == {CHECK, 8'ha5})
    else $error("integrity word wrong");
  dsm_words_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (addr_in == 8'd105 || addr_in == 8'd169)
    |=> data_out == ($past(addr_in) == 8'd105 ? 16'h0008 : 16'h0001))
    else $error("data set management word wrong");
  download_words_a: assert property (@(posedge clk_in) disable iff (rst_in)
    addr_in == 8'd234 ##1 addr_in == 8'd235
    |=> data_out == 16'h0080 && $past(data_out) == 16'h0001)
    else $error("download limit words wrong");
  media_words_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (addr_in == 8'd217 || addr_in == 8'd222)
    |=> data_out == ($past(addr_in) == 8'd217 ? 16'h0001 : 16'h107f))
    else $error("media or transport word wrong");
  zero_words_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (addr_in >= 8'd210 && addr_in <= 8'd213) || addr_in == 8'd223
    |=> data_out == 16'h0000)
    else $error("unsupported feature word not zero");
endmodule

// >>> rtl/atir_taskfile.sv
// atir_taskfile: command block registers over apb with identify data out
//
// Register access over APB is this design's own decision.
module atir_taskfile
  import atir_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CAP_SEL = 0,
  parameter logic [3:0] FORM = 4'h3
) (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // command hand-off to the back end
  output logic CMD_STROBE_OUT,
  output logic [7:0] CMD_CODE_OUT,
  output logic [7:0] FEATURE_OUT,
  output logic [7:0] COUNT_OUT,
  output logic [27:0] LBA_OUT,
  input wire logic CMD_DONE_IN,
  input wire logic CMD_FAIL_IN,
  // host data words toward the back end
  output logic WR_VALID_OUT,
  output logic [15:0] WR_DATA_OUT,
  // interrupt
  output logic IRQ_OUT
);
  if (ADDR_W < 6 || ADDR_W > 32) begin : bad_addr_w
    $error("atir_taskfile: ADDR_W must lie in 6..32");
  end

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] feature;
    logic [7:0] fault;
    logic [7:0] count;
    logic [7:0] lba_low;
    logic [7:0] lba_mid;
    logic [7:0] lba_high;
    logic [7:0] unit;
    logic bsy;
    logic drq;
    logic err;
    logic [7:0] ptr;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic irq;
    logic cmd_strobe;
    logic [7:0] cmd_code;
    logic [7:0] cmd_feature;
    logic [7:0] cmd_count;
    logic [27:0] lba;
    logic wr_valid;
    logic [15:0] wr_data;
  } atir_tf_state_type;

  atir_tf_state_type s;
  atir_tf_state_type next_s;

  logic [15:0] rom_q;
  logic [3:0] idx;
  logic upper_zero;
  logic mapped;
  logic setup;
  logic done;
  logic wr_done;
  logic rd_done;
  logic [7:0] status;
  logic [7:0] wbyte;
  logic [31:0] rd_value;
  logic [1:0] ev;

  // identify table, addressed by the pointer it will hold next
  atir_id_rom #(
    .CAP_SEL(CAP_SEL),
    .FORM(FORM)
  ) u_rom (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .addr_in(next_s.ptr),
    .data_out(rom_q)
  );

  // address decode
  assign idx = PADDR_IN[5:2];
  if (ADDR_W > 6) begin : g_upper
    assign upper_zero = (PADDR_IN[ADDR_W-1:6] == '0);
  end else begin : g_no_upper
    assign upper_zero = 1'b1;
  end
  assign mapped = upper_zero && (PADDR_IN[1:0] == 2'b00) &&
    (idx <= ATIR_IDX_ID_PTR);

  // apb phases: answer one cycle after setup, effect at completion
  assign setup = PSEL_IN && !PENABLE_IN && !s.pready;
  assign done = PSEL_IN && PENABLE_IN && s.pready;
  assign wr_done = done && PWRITE_IN && mapped;
  assign rd_done = done && !PWRITE_IN && mapped;
  assign wbyte = PWDATA_IN[7:0];

  // status byte assembled from live flags
  always_comb begin
    status = 8'h00;
    status[ATIR_ST_BSY] = s.bsy;
    status[ATIR_ST_DRDY] = 1'b1;
    status[ATIR_ST_DRQ] = s.drq;
    status[ATIR_ST_ERR] = s.err;
  end

  // read multiplexer
  always_comb begin
    rd_value = 32'h0000_0000;
    if (!mapped) begin
      rd_value = 32'h0000_0000;
    end else if (idx == ATIR_IDX_DATA) begin
      rd_value[15:0] = s.drq ? rom_q : s.wr_data;
    end else if (idx == ATIR_IDX_FAULT) begin
      rd_value[7:0] = s.fault;
    end else if (idx == ATIR_IDX_COUNT) begin
      rd_value[7:0] = s.count;
    end else if (idx == ATIR_IDX_LBA_LOW) begin
      rd_value[7:0] = s.lba_low;
    end else if (idx == ATIR_IDX_LBA_MID) begin
      rd_value[7:0] = s.lba_mid;
    end else if (idx == ATIR_IDX_LBA_HIGH) begin
      rd_value[7:0] = s.lba_high;
    end else if (idx == ATIR_IDX_UNIT) begin
      rd_value[7:0] = s.unit;
    end else if (idx == ATIR_IDX_OPCODE) begin
      rd_value[7:0] = status;
    end else if (idx == ATIR_IDX_IRQ_ST) begin
      rd_value[1:0] = s.irq_st;
    end else if (idx == ATIR_IDX_IRQ_MASK) begin
      rd_value[1:0] = s.irq_mask;
    end else begin
      rd_value[8:0] = {s.drq, s.ptr};
    end
  end

  always_comb begin
    next_s = s;
    ev = 2'b00;
    next_s.cmd_strobe = 1'b0;
    next_s.wr_valid = 1'b0;
    if (setup) begin
      next_s.pready = 1'b1;
      next_s.pslverr = !mapped;
      next_s.prdata = rd_value;
    end
    if (done) begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end
    // taskfile bytes ignored while a command owns them
    if (wr_done && !s.bsy && !s.drq) begin
      if (idx == ATIR_IDX_FAULT) begin
        next_s.feature = wbyte;
      end else if (idx == ATIR_IDX_COUNT) begin
        next_s.count = wbyte;
      end else if (idx == ATIR_IDX_LBA_LOW) begin
        next_s.lba_low = wbyte;
      end else if (idx == ATIR_IDX_LBA_MID) begin
        next_s.lba_mid = wbyte;
      end else if (idx == ATIR_IDX_LBA_HIGH) begin
        next_s.lba_high = wbyte;
      end else if (idx == ATIR_IDX_UNIT) begin
        next_s.unit = wbyte;
      end else if (idx == ATIR_IDX_OPCODE) begin
        next_s.err = 1'b0;
        next_s.fault = ATIR_RST_BYTE;
        next_s.cmd_code = wbyte;
        next_s.cmd_feature = s.feature;
        next_s.cmd_count = s.count;
        next_s.lba = {s.unit[3:0], s.lba_high, s.lba_mid, s.lba_low};
        if (wbyte == ATIR_CMD_IDENTIFY) begin
          next_s.drq = 1'b1;
          next_s.ptr = 8'h00;
          ev[ATIR_EV_DRQ] = 1'b1;
        end else begin
          next_s.bsy = 1'b1;
          next_s.cmd_strobe = 1'b1;
        end
      end
    end
    if (wr_done && idx == ATIR_IDX_DATA) begin
      next_s.wr_data = PWDATA_IN[15:0];
      next_s.wr_valid = 1'b1;
    end
    if (wr_done && idx == ATIR_IDX_IRQ_MASK) begin
      next_s.irq_mask = PWDATA_IN[1:0];
    end
    // each data read while drq is set steps to the next identify word
    if (rd_done && idx == ATIR_IDX_DATA && s.drq) begin
      next_s.ptr = s.ptr + 8'h01;
      if (s.ptr == ATIR_W_INTEGRITY) begin
        next_s.drq = 1'b0;
        ev[ATIR_EV_DONE] = 1'b1;
      end
    end
    if (s.bsy && CMD_DONE_IN) begin
      next_s.bsy = 1'b0;
      next_s.err = CMD_FAIL_IN;
      next_s.fault = CMD_FAIL_IN ? ATIR_ERR_ABRT : ATIR_RST_BYTE;
      ev[ATIR_EV_DONE] = 1'b1;
    end
    // read clears only the bits it reported; a new event wins
    next_s.irq_st = s.irq_st | ev;
    if (rd_done && idx == ATIR_IDX_IRQ_ST) begin
      next_s.irq_st = (s.irq_st & ~s.prdata[1:0]) | ev;
    end
    next_s.irq = |(next_s.irq_st & next_s.irq_mask);
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      s <= '0;
      s.irq_mask <= ATIR_RST_MASK;
      s.unit <= ATIR_RST_BYTE;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA_OUT = s.prdata;
  assign PREADY_OUT = s.pready;
  assign PSLVERR_OUT = s.pslverr;
  assign CMD_STROBE_OUT = s.cmd_strobe;
  assign CMD_CODE_OUT = s.cmd_code;
  assign FEATURE_OUT = s.cmd_feature;
  assign COUNT_OUT = s.cmd_count;
  assign LBA_OUT = s.lba;
  assign WR_VALID_OUT = s.wr_valid;
  assign WR_DATA_OUT = s.wr_data;
  assign IRQ_OUT = s.irq;

  apb_answer_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    setup |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("apb answer not one cycle after setup");
  data_word_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    setup && !PWRITE_IN && mapped && idx == ATIR_IDX_DATA && s.drq
    |=> PRDATA_OUT == {16'h0000, $past(rom_q)})
    else $error("data port did not return identify word");
  feature_write_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    wr_done && idx == ATIR_IDX_FAULT && !s.bsy && !s.drq
    |=> s.feature == $past(wbyte) && s.fault == $past(s.fault))
    else $error("feature write touched the error byte");
  status_read_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    setup && !PWRITE_IN && mapped && idx == ATIR_IDX_OPCODE
    |=> PRDATA_OUT[7:0] == {$past(s.bsy), 1'b1, 2'b00, $past(s.drq),
      2'b00, $past(s.err)})
    else $error("status read wrong");
  byte_echo_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    wr_done && idx == ATIR_IDX_COUNT && !s.bsy && !s.drq
    ##1 setup && !PWRITE_IN && idx == ATIR_IDX_COUNT
    |=> PRDATA_OUT[7:0] == s.count)
    else $error("count byte did not read back");
  lba_form_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    CMD_STROBE_OUT |-> LBA_OUT == {s.unit[3:0], s.lba_high, s.lba_mid,
      s.lba_low} && s.bsy)
    else $error("28-bit address not assembled");
  ident_start_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    wr_done && idx == ATIR_IDX_OPCODE && wbyte == ATIR_CMD_IDENTIFY &&
    !s.bsy && !s.drq |=> s.drq && s.ptr == 8'h00 && !CMD_STROBE_OUT)
    else $error("identify did not start at word zero");
  word_order_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    rd_done && idx == ATIR_IDX_DATA && s.drq
    |=> s.ptr == 8'($past(s.ptr) + 8'h01) &&
      s.drq == ($past(s.ptr) != 8'hff))
    else $error("identify words out of order");
  irq_level_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    IRQ_OUT == |(s.irq_st & s.irq_mask))
    else $error("interrupt level does not follow status and mask");
  map_error_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    setup |=> PSLVERR_OUT == !$past(mapped))
    else $error("error response does not follow the map");
  map_zero_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    setup && !mapped |=> PRDATA_OUT == 32'h0000_0000)
    else $error("unmapped read returned data");
  fault_read_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    setup && !PWRITE_IN && mapped && idx == ATIR_IDX_FAULT
    |=> PRDATA_OUT == {24'h000000, $past(s.fault)})
    else $error("error byte read wrong");
  opcode_take_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    wr_done && idx == ATIR_IDX_OPCODE && wbyte != ATIR_CMD_IDENTIFY &&
    !s.bsy && !s.drq
    |=> CMD_STROBE_OUT && s.bsy && CMD_CODE_OUT == $past(wbyte) &&
      FEATURE_OUT == $past(s.feature) && COUNT_OUT == $past(s.count))
    else $error("command opcode not handed over");
  strobe_pulse_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    CMD_STROBE_OUT |=> !CMD_STROBE_OUT)
    else $error("command strobe longer than one cycle");
  busy_guard_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    wr_done && idx != ATIR_IDX_DATA && idx != ATIR_IDX_IRQ_MASK &&
    (s.bsy || s.drq)
    |=> s.count == $past(s.count) && s.unit == $past(s.unit) &&
      s.lba_low == $past(s.lba_low) && !CMD_STROBE_OUT)
    else $error("taskfile changed while a command owns it");
  host_word_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    wr_done && idx == ATIR_IDX_DATA
    |=> WR_VALID_OUT && WR_DATA_OUT == $past(PWDATA_IN[15:0]))
    else $error("host data word not passed on");
  host_echo_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    setup && !PWRITE_IN && mapped && idx == ATIR_IDX_DATA && !s.drq
    |=> PRDATA_OUT == {16'h0000, WR_DATA_OUT})
    else $error("data port did not return host word");
  cmd_end_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    s.bsy && CMD_DONE_IN
    |=> !s.bsy && s.err == $past(CMD_FAIL_IN) && s.irq_st[ATIR_EV_DONE])
    else $error("command end not reported");
  irq_clear_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    rd_done && idx == ATIR_IDX_IRQ_ST && ev == 2'b00
    |=> (s.irq_st & $past(s.prdata[1:0])) == 2'b00)
    else $error("status read did not clear reported bits");
  irq_set_a: assert property (@(posedge REF_CLK_IN)
    disable iff (SYS_RST_IN)
    ev != 2'b00 |=> (s.irq_st & $past(ev)) == $past(ev))
    else $error("interrupt event lost");
endmodule

// >>> sim/atir_backend_model.sv
// atir_backend_model: back end answering accepted commands after a delay
module atir_backend_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // command side
  input wire logic strobe_in,
  input wire logic fail_req_in,
  input wire logic [4:0] delay_in,
  output logic done_out,
  output logic fail_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = -1;
  initial begin
    done_out = 1'b0;
    fail_out = 1'b0;
  end
  // fail is only meaningful with done; it toggles otherwise
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    fail_out <= ~fail_out;
    if (rst_in) begin
      left = -1;
    end else if (strobe_in) begin
      left = delay_in;
    end else if (left > 0) begin
      left = left - 1;
    end else if (left == 0) begin
      done_out <= 1'b1;
      fail_out <= fail_req_in;
      left = -1;
    end
  end
endmodule

// >>> sim/atir_taskfile_bench.sv
// atir_taskfile_bench: apb tests of the taskfile bank and identify table
module atir_taskfile_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import atir_pkg::*;
  logic clk, rst, psel, pen, pwr, pready, pslverr, er;
  logic strobe, wr_valid, irq, done, fail, fail_req;
  logic [7:0] paddr, code, feat, cnt, sum, cks;
  logic [31:0] pwdata, prdata, rd;
  logic [27:0] lba;
  logic [15:0] wr_data, wexp;
  logic [4:0] delay;
  int errors = 0;
  int cmp_count = 0;
  int strobes = 0;
  int wr_pulses = 0;
  bit chain = 1'b0;

  atir_taskfile #(.ADDR_W(8), .CAP_SEL(0), .FORM(4'h4)) i_dut (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .CMD_STROBE_OUT(strobe), .CMD_CODE_OUT(code), .FEATURE_OUT(feat),
    .COUNT_OUT(cnt), .LBA_OUT(lba), .CMD_DONE_IN(done),
    .CMD_FAIL_IN(fail), .WR_VALID_OUT(wr_valid),
    .WR_DATA_OUT(wr_data), .IRQ_OUT(irq));

  atir_backend_model i_back (
    .clk_in(clk), .rst_in(rst), .strobe_in(strobe),
    .fail_req_in(fail_req), .delay_in(delay),
    .done_out(done), .fail_out(fail));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (strobe === 1'b1) strobes <= strobes + 1;
    if (wr_valid === 1'b1) wr_pulses <= wr_pulses + 1;
  end

  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer, entered just after a rising edge; unless chained it
  // releases the bus and lets one idle edge pass
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
    end
    rd = prdata;
    er = pslverr;
    if (chain) begin
      chain = 1'b0;
    end else begin
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
    apb(1'b1, {2'h0, idx, 2'h0}, wd);
  endtask

  task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
    apb(1'b0, {2'h0, idx, 2'h0}, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h1c, 32'h0);
      n++;
    end while (rd[7] !== 1'b0 && n < 40);
    chk(rd[7], 1'b0);
  endtask

  function automatic logic [15:0] idw(input int i);
    case (i)
      60, 100: idw = 16'h0ab0;
      61, 101: idw = 16'h0774;
      105: idw = 16'h0008;
      106, 209: idw = 16'h4000;
      119, 120: idw = 16'h4014;
      128: idw = 16'h0021;
      141, 169, 217, 234: idw = 16'h0001;
      168: idw = 16'h0004;
      222: idw = 16'h107f;
      235: idw = 16'h0080;
      default: idw = 16'h0000;
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_req = 1'b0;
    delay = 5'h14;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(4'h7, 32'h40);
    rdc(4'h9, 32'h0);
    rdc(4'h8, 32'h0);
    for (int i = 1; i < 7; i++) wr(4'(i), 32'h30 + 32'(i));
    chain = 1'b1;
    wr(4'h2, 32'h32);
    for (int i = 2; i < 7; i++) rdc(4'(i), 32'h30 + 32'(i));
    rdc(4'h1, 32'h0);
    // slow command; writes while busy are dropped
    wr(4'h7, 32'hc8);
    rdc(4'h7, 32'hc0);
    wr(4'h2, 32'hff);
    wait_idle();
    rdc(4'h2, 32'h32);
    chk(code, 8'hc8);
    chk(feat, 8'h31);
    chk(cnt, 8'h32);
    chk(lba, 28'h6353433);
    chk(strobes, 1);
    // masked event, then unmask, then clear on read
    chk(irq, 1'b0);
    wr(4'h9, 32'h3);
    chk(irq, 1'b1);
    rdc(4'h8, 32'h2);
    chk(irq, 1'b0);
    // data port both ways
    wr(4'h0, 32'h0000beef);
    chk(wr_data, 16'hbeef);
    rdc(4'h0, 32'h0000beef);
    chk(wr_pulses, 1);
    // unmapped and misaligned
    apb(1'b0, 8'h2c, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h09, 32'hff);
    chk(er, 1'b1);
    rdc(4'h2, 32'h32);
    chk(er, 1'b0);
    // identify sector
    wr(4'h7, 32'hec);
    rdc(4'h7, 32'h48);
    rdc(4'h8, 32'h1);
    sum = 8'ha5;
    for (int i = 0; i < 255; i++) begin
      apb(1'b0, 8'h00, 32'h0);
      wexp = idw(i);
      sum = sum + wexp[7:0] + wexp[15:8];
      chk(rd, {16'h0, wexp});
    end
    cks = 8'h00 - sum;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, {16'h0, cks, 8'ha5});
    rdc(4'h7, 32'h40);
    rdc(4'h8, 32'h2);
    chk(strobes, 1);
    // failing command, prompt answer
    fail_req <= 1'b1;
    delay <= 5'h00;
    wr(4'h7, 32'h20);
    wait_idle();
    chk(rd, 32'h41);
    rdc(4'h1, 32'h04);
    chk(code, 8'h20);
    chk(strobes, 2);
    give_verdict();
  end
endmodule
